// ### hw/adc_host_pkg.sv
package adc_host_pkg;
	// ==========================================================
	// register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_OFFSET = 8'h04;
	localparam logic [7:0] REG_CMD = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RESULT = 8'h10;
	// field positions
	localparam int unsigned CTRL_MODE_TWO_BIT = 0;
	localparam int unsigned CTRL_SAT_BIT = 1;
	localparam int unsigned CMD_START_BIT = 0;
	localparam int unsigned STAT_BUSY_BIT = 0;
	localparam int unsigned STAT_DONE_BIT = 1;
	localparam int unsigned STAT_OFF_ERR_BIT = 2;
	localparam int unsigned STAT_WR_PEND_BIT = 3;
	localparam int unsigned RES_RANGE_BIT = 16;
	localparam int unsigned RES_SIGN_BIT = 17;
	localparam int unsigned RES_PREV_BIT = 18;
	// reset values
	localparam logic CTRL_RST_MODE_TWO = 1'b0;
	localparam logic CTRL_RST_SAT = 1'b1;
	localparam logic [9:0] OFFSET_RST = 10'h000;
	// offset span
	localparam int OFFSET_MIN = -327;
	localparam int OFFSET_MAX = 327;
	// ==========================================================
	// timing
	localparam int unsigned CLK_FREQ_MHZ = 10;
	localparam int unsigned TRIG_LOW_NS = 100;
	localparam int unsigned WR_PULSE_NS = 100;
	localparam int unsigned RD_ACCESS_NS = 100;
	localparam int unsigned QUIET_NS = 100;
	localparam int unsigned MODE_ONE_PERIOD_NS = 400;
	// least time in ns to whole cycles, never below one
	function automatic int unsigned ns_to_cyc(input int unsigned ns);
		int unsigned c;
		c = (ns * CLK_FREQ_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction : ns_to_cyc
	localparam int unsigned TRIG_CYC = ns_to_cyc(TRIG_LOW_NS);
	localparam int unsigned WR_CYC = ns_to_cyc(WR_PULSE_NS);
	localparam int unsigned RD_CYC = ns_to_cyc(RD_ACCESS_NS);
	localparam int unsigned QUIET_CYC = ns_to_cyc(QUIET_NS);
	localparam int unsigned MODE_ONE_CYC = ns_to_cyc(MODE_ONE_PERIOD_NS);
	// ==========================================================
	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WRITE = 3'b001,
		ST_TRIG = 3'b010,
		ST_WAIT_LOW = 3'b011,
		ST_WAIT_HIGH = 3'b100,
		ST_READ = 3'b101,
		ST_QUIET = 3'b110
	} state_t;
endpackage : adc_host_pkg

// ### hw/result_if.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// raw bus word to decoded value
interface result_if;
	logic [12:0] word;
	logic signed [15:0] value;
	logic range_flag;
	logic sign_flag;
	modport decoder (input word, output value, range_flag, sign_flag);
	modport user (output word, input value, range_flag, sign_flag);
endinterface : result_if
`default_nettype wire

// ### hw/result_decode.sv
`timescale 1ns/100ps
`default_nettype none
module result_decode (
	result_if.decoder r
);
	// ==========================================================
	// flag decode
	always_comb begin
		r.range_flag = r.word[12];
		r.sign_flag = r.word[12] & r.word[11];
		if (r.sign_flag) begin
			r.value = {{3{r.word[12]}}, r.word};
		end else if (r.range_flag) begin
			r.value = {3'b000, r.word};
		end else begin
			r.value = {4'b0000, r.word[11:0]};
		end
	end
endmodule : result_decode
`default_nettype wire

// ### hw/adc_host_ctrl.sv
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module adc_host_ctrl #(
	parameter int unsigned CNT_W = 8
) (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_ce,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	output logic o_sample_trigger_n,
	input wire logic i_busy,
	output logic o_select_n,
	output logic o_read_n,
	output logic o_write_n,
	input wire logic [12:0] i_result_bus,
	output logic [12:0] o_result_bus,
	output logic o_result_bus_oe,
	output logic [1:0] o_mode_sel,
	output logic o_saturate_select
);
	// ==========================================================
	// elaboration checks
	if (adc_host_pkg::TRIG_CYC >= 2 ** CNT_W || adc_host_pkg::WR_CYC >= 2 ** CNT_W ||
		adc_host_pkg::RD_CYC >= 2 ** CNT_W || adc_host_pkg::QUIET_CYC >= 2 ** CNT_W) begin : g_bad
		$error("counter too narrow for timing counts");
	end
	if (CNT_W < 2) begin : g_narrow
		$error("counter width below two");
	end
	// mode one pacing
	// trigger, two busy waits, read, quiet and idle bound the loop from below
	if (adc_host_pkg::TRIG_CYC + adc_host_pkg::RD_CYC + adc_host_pkg::QUIET_CYC + 3 <
		adc_host_pkg::MODE_ONE_CYC) begin : g_fast
		$error("sequencer loop faster than mode one limit");
	end

	// ==========================================================
	// state
	typedef struct packed {
		adc_host_pkg::state_t st;
		logic [CNT_W-1:0] cnt;
		logic mode_two;
		logic sat;
		logic [9:0] offset;
		logic [12:0] wr_word;
		logic wr_pend;
		logic conv_pend;
		logic done;
		logic off_err;
		logic prev;
		logic [12:0] raw;
		logic [31:0] rdata;
	} host_state_t;

	host_state_t q;
	host_state_t d;
	logic signed [15:0] wr_val;
	logic wr_ok;

	result_if res ();

	result_decode u_decode (
		.r(res.decoder)
	);

	assign res.word = q.raw;

	// offset span check on a software value
	function automatic logic in_span(input logic signed [15:0] v);
		return (v >= 16'(adc_host_pkg::OFFSET_MIN)) && (v <= 16'(adc_host_pkg::OFFSET_MAX));
	endfunction : in_span

	// counter load value for a cycle count
	function automatic logic [CNT_W-1:0] load(input int unsigned cyc);
		return CNT_W'(cyc - 1);
	endfunction : load

	assign wr_val = i_wdata[15:0];
	assign wr_ok = in_span(wr_val);

	// ==========================================================
	// next state
	always_comb begin
		d = q;
		d.rdata = 32'h0000_0000;
		// register writes
		if (i_wr) begin
			unique case (i_addr)
				adc_host_pkg::REG_CTRL: begin
					d.mode_two = i_wdata[adc_host_pkg::CTRL_MODE_TWO_BIT];
					d.sat = i_wdata[adc_host_pkg::CTRL_SAT_BIT];
				end
				adc_host_pkg::REG_OFFSET: begin
					// newest write replaces the pending one
					if (wr_ok) begin
						d.offset = wr_val[9:0];
						d.wr_pend = 1'b1;
					end else begin
						d.off_err = 1'b1;
					end
				end
				adc_host_pkg::REG_CMD: begin
					if (i_wdata[adc_host_pkg::CMD_START_BIT]) begin
						d.conv_pend = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		// register reads, clear-on-read flags lose to a same-cycle set, off_err's above, done's below
		if (i_rd) begin
			unique case (i_addr)
				adc_host_pkg::REG_CTRL: begin
					d.rdata[adc_host_pkg::CTRL_MODE_TWO_BIT] = q.mode_two;
					d.rdata[adc_host_pkg::CTRL_SAT_BIT] = q.sat;
				end
				adc_host_pkg::REG_STATUS: begin
					d.rdata[adc_host_pkg::STAT_BUSY_BIT] = (q.st != adc_host_pkg::ST_IDLE);
					d.rdata[adc_host_pkg::STAT_DONE_BIT] = q.done;
					d.rdata[adc_host_pkg::STAT_OFF_ERR_BIT] = q.off_err;
					d.rdata[adc_host_pkg::STAT_WR_PEND_BIT] = q.wr_pend;
					if (!(i_wr && i_addr == adc_host_pkg::REG_OFFSET && !wr_ok)) begin
						d.off_err = 1'b0;
					end
				end
				adc_host_pkg::REG_RESULT: begin
					d.rdata[15:0] = res.value;
					d.rdata[adc_host_pkg::RES_RANGE_BIT] = res.range_flag;
					d.rdata[adc_host_pkg::RES_SIGN_BIT] = res.sign_flag;
					d.rdata[adc_host_pkg::RES_PREV_BIT] = q.prev;
					d.done = 1'b0;
				end
				default: begin
				end
			endcase
		end
		// sequencer
		unique case (q.st)
			adc_host_pkg::ST_IDLE: begin
				// offset write goes out only while idle
				if (q.wr_pend) begin
					d.st = adc_host_pkg::ST_WRITE;
					// top three bits forced to zero
					d.wr_word = {3'b000, q.offset};
					d.wr_pend = (i_wr && i_addr == adc_host_pkg::REG_OFFSET && wr_ok);
					d.cnt = load(adc_host_pkg::WR_CYC);
				end else if (q.conv_pend) begin
					// trigger falls to start a conversion
					d.st = adc_host_pkg::ST_TRIG;
					d.conv_pend = i_wr && i_addr == adc_host_pkg::REG_CMD &&
						i_wdata[adc_host_pkg::CMD_START_BIT];
					d.cnt = load(adc_host_pkg::TRIG_CYC);
				end
			end
			adc_host_pkg::ST_WRITE: begin
				if (q.cnt == '0) begin
					d.st = adc_host_pkg::ST_QUIET;
					d.cnt = load(adc_host_pkg::QUIET_CYC);
				end else begin
					d.cnt = q.cnt - 1'b1;
				end
			end
			adc_host_pkg::ST_TRIG: begin
				if (q.cnt == '0) begin
					d.st = adc_host_pkg::ST_WAIT_LOW;
				end else begin
					d.cnt = q.cnt - 1'b1;
				end
			end
			adc_host_pkg::ST_WAIT_LOW: begin
				if (!i_busy) begin
					d.st = adc_host_pkg::ST_WAIT_HIGH;
				end
			end
			adc_host_pkg::ST_WAIT_HIGH: begin
				// read only once busy has risen
				if (i_busy) begin
					d.st = adc_host_pkg::ST_READ;
					d.cnt = load(adc_host_pkg::RD_CYC);
				end
			end
			adc_host_pkg::ST_READ: begin
				if (q.cnt == '0) begin
					// mode one word is this conversion
					// mode two word is the previous sample
					d.raw = i_result_bus;
					d.prev = q.mode_two;
					d.done = 1'b1;
					d.st = adc_host_pkg::ST_QUIET;
					d.cnt = load(adc_host_pkg::QUIET_CYC);
				end else begin
					d.cnt = q.cnt - 1'b1;
				end
			end
			adc_host_pkg::ST_QUIET: begin
				if (q.cnt == '0) begin
					d.st = adc_host_pkg::ST_IDLE;
				end else begin
					d.cnt = q.cnt - 1'b1;
				end
			end
			default: begin
				d.st = adc_host_pkg::ST_IDLE;
			end
		endcase
	end

	// ==========================================================
	// state register
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			q.st <= adc_host_pkg::ST_IDLE;
			q.cnt <= '0;
			q.mode_two <= adc_host_pkg::CTRL_RST_MODE_TWO;
			q.sat <= adc_host_pkg::CTRL_RST_SAT;
			q.offset <= adc_host_pkg::OFFSET_RST;
			q.wr_word <= 13'h0000;
			q.wr_pend <= 1'b0;
			q.conv_pend <= 1'b0;
			q.done <= 1'b0;
			q.off_err <= 1'b0;
			q.prev <= 1'b0;
			q.raw <= 13'h0000;
			q.rdata <= 32'h0000_0000;
		end else if (i_ce) begin
			q <= d;
		end
	end

	// ==========================================================
	// pins
	assign o_rdata = q.rdata;
	assign o_select_n = !(q.st == adc_host_pkg::ST_WRITE || q.st == adc_host_pkg::ST_READ);
	assign o_read_n = (q.st != adc_host_pkg::ST_READ);
	assign o_write_n = (q.st != adc_host_pkg::ST_WRITE);
	assign o_sample_trigger_n = (q.st != adc_host_pkg::ST_TRIG);
	assign o_result_bus = q.wr_word;
	// host drives only during its own write
	assign o_result_bus_oe = (q.st == adc_host_pkg::ST_WRITE);
	// pin0 for mode one, pin1 for mode two
	assign o_mode_sel = q.mode_two ? 2'b10 : 2'b01;
	assign o_saturate_select = q.sat;

	// ==========================================================
	// checks
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	a_offset_span: assert property (!o_write_n |->
		($signed(o_result_bus[9:0]) >= adc_host_pkg::OFFSET_MIN) &&
		($signed(o_result_bus[9:0]) <= adc_host_pkg::OFFSET_MAX))
		else $error("offset written out of span");
	a_upper_zero: assert property (o_result_bus_oe |-> o_result_bus[12:10] == 3'b000)
		else $error("offset word upper bits nonzero");
	a_write_idle: assert property ($fell(o_write_n) |-> $past(q.st) == adc_host_pkg::ST_IDLE)
		else $error("offset write started outside idle");
	a_mode_pins: assert property (o_mode_sel[0] != o_mode_sel[1])
		else $error("mode pins equal");
	a_read_window: assert property ($fell(o_read_n) |-> $past(i_busy))
		else $error("read started while busy low");
	a_bus_release: assert property (o_result_bus_oe |-> o_read_n && !o_select_n && !o_write_n)
		else $error("host drives bus outside write");
	a_quiet_gap: assert property (($rose(o_read_n) || $rose(o_write_n)) && i_ce |->
		o_sample_trigger_n[*2])
		else $error("trigger inside quiet interval");
	a_trig_pulse: assert property ($fell(o_sample_trigger_n) && i_ce |->
		##1 (o_sample_trigger_n && o_read_n && o_write_n))
		else $error("trigger pulse length wrong");
	a_write_strobe: assert property (!o_write_n |-> !o_select_n && o_read_n && o_result_bus_oe)
		else $error("write strobe without select");
	a_capture: assert property ($rose(o_read_n) && i_ce |-> q.done)
		else $error("read ended without done");
	a_trig_pace: assert property ($fell(o_sample_trigger_n) && i_ce |=>
		o_sample_trigger_n[*3])
		else $error("trigger falls too soon after previous");
	// read data stands for one cycle only
	a_rdata_idle: assert property ($past(i_ce) && !$past(i_rd) |-> o_rdata == 32'h0000_0000)
		else $error("read data outside its cycle");

	c_offset_write: cover property ($rose(o_write_n));
	c_mode_one_read: cover property ($rose(o_read_n) && !q.mode_two);
	c_mode_two_read: cover property ($rose(o_read_n) && q.mode_two);
	c_negative: cover property (q.done && res.sign_flag);
endmodule : adc_host_ctrl
`default_nettype wire

// ### test/adc_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// converter behaviour seen at its pins
module adc_dev_model (
	input wire logic i_trig_n,
	input wire logic i_sel_n,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic [1:0] i_mode,
	input wire logic i_sat,
	input wire logic [12:0] i_bus,
	input wire logic [11:0] i_raw,
	input wire logic i_slow,
	output logic o_busy,
	output logic [12:0] o_data,
	output logic o_oe,
	output int o_fault
);
	int off = 0;
	int v;
	logic [12:0] outreg = 13'h0000;
	logic [12:0] pend = 13'h0000;
	realtime t_bus = 0;
	realtime t_trig = -1000;
	initial o_busy = 1'b1;
	initial o_fault = 0;
	always @(negedge i_trig_n) begin
		if (i_mode[0] == i_mode[1] || $realtime - t_bus < 100
			|| (i_mode[0] && $realtime - t_trig < 400))
			o_fault++;
		t_trig = $realtime;
		if (i_mode[1])
			outreg = pend;
		v = int'(i_raw) + off;
		o_busy = 1'b0;
		#(i_slow ? 1250 : 330); // kept off the host clock edge
		if (i_sat)
			v = v < 0 ? 0 : (v > 4095 ? 4095 : v);
		pend = v[12:0];
		// mode one loads at busy rise
		if (i_mode[0])
			outreg = pend;
		o_busy = 1'b1;
	end
	always @(negedge i_wr_n) begin
		#50;
		if (!i_sel_n) begin
			if (i_bus[12:10] != 3'b000 || !o_busy)
				o_fault++;
			off = int'(signed'(i_bus[9:0]));
		end
	end
	// bus activity end for the quiet gap
	always @(posedge i_rd_n or posedge i_wr_n)
		t_bus = $realtime;
	// drive only while selected and read
	assign o_oe = !i_sel_n && !i_rd_n;
	assign o_data = outreg;
	always @(posedge o_oe)
		if (!o_busy)
			o_fault++;
endmodule : adc_dev_model
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// self-checking bench for the host controller
module tb;
	logic i_ref_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0000_0000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [31:0] o_rdata;
	logic trig_n, busy, sel_n, rd_n, wr_n, h_oe, d_oe, sat;
	logic slow = 1'b0;
	logic ce = 1'b1;
	logic [1:0] mode;
	logic [12:0] h_bus, d_bus, bus;
	logic [12:0] last = 13'h0000;
	logic [11:0] raw = 12'h000;
	int fault;
	int fail_count = 0;
	int checks_done = 0;
	int off_m = 0;
	logic [31:0] out_m = 32'h0000_0000;
	logic [31:0] pend_m = 32'h0000_0000;
	logic [31:0] d;
	// released lines show the inverse of the last level
	assign bus = h_oe ? h_bus : (d_oe ? d_bus : ~last);
	always @(bus)
		if (h_oe || d_oe)
			last = bus;
	initial forever #50 i_ref_clk = ~i_ref_clk;
	adc_host_ctrl u_dut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_ce(ce),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_sample_trigger_n(trig_n), .i_busy(busy), .o_select_n(sel_n), .o_read_n(rd_n),
		.o_write_n(wr_n), .i_result_bus(bus), .o_result_bus(h_bus),
		.o_result_bus_oe(h_oe), .o_mode_sel(mode), .o_saturate_select(sat));
	adc_dev_model u_dev (.i_trig_n(trig_n), .i_sel_n(sel_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
		.i_mode(mode), .i_sat(sat), .i_bus(bus), .i_raw(raw), .i_slow(slow),
		.o_busy(busy), .o_data(d_bus), .o_oe(d_oe), .o_fault(fault));
	// register bus cycles
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wdata <= x;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask : rd
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task automatic conclude();
		if (fail_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude
	// one conversion against the integer model
	task automatic convert(input int r, input int of, input logic st, input logic md,
		input logic w);
		int k;
		int v;
		raw <= 12'(r);
		slow <= 1'($urandom);
		wr(adc_host_pkg::REG_CTRL, {30'h0, st, md});
		if (w) begin
			wr(adc_host_pkg::REG_OFFSET, 32'(of));
			if (of >= adc_host_pkg::OFFSET_MIN && of <= adc_host_pkg::OFFSET_MAX)
				off_m = of;
			else begin
				rd(adc_host_pkg::REG_STATUS);
				cmp("off_err", 32'h0000_0004, d & 32'h0000_0004);
			end
		end
		wr(adc_host_pkg::REG_CMD, 32'h0000_0001);
		k = 0;
		do begin
			rd(adc_host_pkg::REG_STATUS);
			k++;
		end while (d[1] !== 1'b1 && k < 100);
		cmp("done", 32'h0000_0001, {31'h0, d[1]});
		v = r + off_m;
		if (st)
			v = v < 0 ? 0 : (v > 4095 ? 4095 : v);
		if (md)
			out_m = pend_m;
		pend_m = {14'h0, v < 0, v < 0 || v > 4095, 16'(v)};
		if (!md)
			out_m = pend_m;
		rd(adc_host_pkg::REG_RESULT);
		cmp("result", out_m | {13'h0, md, 18'h0}, d);
	endtask : convert
	// watchdog
	initial begin
		#3_000_000;
		fail_count++;
		conclude();
	end
	// main sequence
	initial begin
		int i;
		void'($urandom(67));
		repeat (8) @(posedge i_ref_clk);
		i_nrst <= 1'b1;
		cmp("pins", 32'h0000_0005, {29'h0, sat, mode});
		rd(adc_host_pkg::REG_CTRL);
		cmp("ctrl", 32'h0000_0002, d);
		rd(8'h20);
		cmp("unmapped", 32'h0000_0000, d);
		// a write under a low clock enable must be lost
		@(posedge i_ref_clk);
		ce <= 1'b0;
		wr(adc_host_pkg::REG_CTRL, 32'h0000_0001);
		ce <= 1'b1;
		rd(adc_host_pkg::REG_CTRL);
		cmp("ctrl frozen", 32'h0000_0002, d);
		cmp("pins frozen", 32'h0000_0005, {29'h0, sat, mode});
		convert(100, 0, 1, 0, 0);
		convert(0, -327, 0, 0, 1);
		convert(4095, 256, 0, 0, 1);
		convert(4095, 0, 1, 0, 0);
		convert(2000, -128, 0, 1, 1);
		convert(3000, 328, 1, 1, 1);
		for (i = 0; i < 24; i++)
			convert($urandom % 4096, int'($urandom % 700) - 350, 1'($urandom),
				1'($urandom), 1'($urandom));
		cmp("faults", 32'h0000_0000, 32'(fault));
		conclude();
	end
endmodule : tb
`default_nettype wire
